// *** rtl/sphp_pkg.sv ***
package sphp_pkg;
  typedef enum logic [1:0] {
    SPHP_PAR_NONE = 2'h0,
    SPHP_PAR_ODD  = 2'h1,
    SPHP_PAR_EVEN = 2'h2
  } sphp_par_t;

  // Gray coded along start, data, parity, stop, stop
  typedef enum logic [2:0] {
    SPHP_TX_IDLE  = 3'h0,
    SPHP_TX_START = 3'h1,
    SPHP_TX_DATA  = 3'h3,
    SPHP_TX_PAR   = 3'h2,
    SPHP_TX_STOP1 = 3'h6,
    SPHP_TX_STOP2 = 3'h7
  } sphp_tx_t;

  // Odd count of ones yields one in even mode, zero in odd mode
  function automatic logic sphp_parity(input logic [7:0] d, input sphp_par_t p);
    sphp_parity = (p == SPHP_PAR_ODD) ? ~(^d) : (^d);
  endfunction
endpackage

// *** rtl/sphp_port.sv ***
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sphp_regs.svh"
module sphp_port
  import sphp_pkg::*;
#(
  parameter int unsigned CLK_HZ = `SPHP_CLK_HZ  // System clock rate in Hz
)
(
  input  wire logic        sys_clk,    // 200 MHz clock
  input  wire logic        rstn,       // Async reset, low
  input  wire logic        clkEn,      // Freeze when low
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hsel,       // AHB select
  input  wire logic        hready,     // AHB bus ready
  output logic [31:0]      hrdata,     // AHB read data
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Always OKAY
  output logic             txd,        // Serial transmit
  input  wire logic        rxd,        // Serial receive
  output logic             rtsN,       // Request to send, low active
  input  wire logic        cts         // Clear to send, mark ready
);
  // ========================================================================
  // Bit-rate tick generator: sixteen ticks per bit
  function automatic logic [15:0] divOf(input logic [2:0] sel);
    int unsigned b;
    case (sel)
      3'h0:    b = `SPHP_BAUD_300;
      3'h1:    b = `SPHP_BAUD_600;
      3'h2:    b = `SPHP_BAUD_1200;
      3'h3:    b = `SPHP_BAUD_2400;
      3'h4:    b = `SPHP_BAUD_4800;
      default: b = `SPHP_BAUD_9600;
    endcase
    // Sixteen-bit divisor: clock rates above about 314.6 MHz overflow at 300 baud
    divOf = 16'(CLK_HZ / (b * `SPHP_OVERSAMPLE) - 1);
  endfunction

  logic [31:0] ctrl_q;
  logic [15:0] divCnt_q;
  logic        tick;
  logic [2:0]  baudSel;
  sphp_par_t   parMode;
  logic        plotMode;

  assign baudSel  = ctrl_q[`SPHP_CTRL_BAUD_MSB:`SPHP_CTRL_BAUD_LSB];
  assign tick     = (divCnt_q == 16'h0000);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      divCnt_q <= 16'h0000;
    else if (clkEn)
      divCnt_q <= tick ? divOf(baudSel) : divCnt_q - 16'h0001;
  end

  // ========================================================================
  // Pin synchronisers: three stages, change accepted when last two agree
  logic [2:0] rxSync_q;
  logic [2:0] ctsSync_q;
  logic       rxLine_q;
  logic       ctsLine_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxSync_q  <= 3'h7;
      ctsSync_q <= 3'h0;
      rxLine_q  <= 1'b1;
      ctsLine_q <= 1'b0;
    end else if (clkEn) begin
      rxSync_q  <= {rxSync_q[1:0], rxd};
      ctsSync_q <= {ctsSync_q[1:0], cts};
      if (rxSync_q[1] == rxSync_q[2])
        rxLine_q <= rxSync_q[2];
      if (ctsSync_q[1] == ctsSync_q[2])
        ctsLine_q <= ctsSync_q[2];
    end
  end

  // ========================================================================
  // AHB-Lite slave: zero wait states, address phase registered
  logic        wrPend_q;
  logic [11:0] aAddr_q;
  logic        rdPend_q;
  logic        accept;
  logic        txReq;
  logic [7:0]  txHold_q;
  logic        txFull_q;
  logic [7:0]  rxData_q;
  logic        rxValid_q;
  logic        parErr_q;
  logic        frmErr_q;
  logic        refused_q;
  logic        plotGo;
  logic        plotEnd;
  logic [2:0]  initIdx_q;

  assign accept    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign txReq     = wrPend_q && aAddr_q == `SPHP_TXDATA_ADDR;
  assign plotGo    = wrPend_q && aAddr_q == `SPHP_CTRL_ADDR && hwdata[`SPHP_CTRL_PLOTGO];
  assign plotEnd   = wrPend_q && aAddr_q == `SPHP_CTRL_ADDR && hwdata[`SPHP_CTRL_PLOTEND];
  assign parMode   = plotMode ? SPHP_PAR_NONE
                              : sphp_par_t'(ctrl_q[`SPHP_CTRL_PAR_MSB:`SPHP_CTRL_PAR_LSB]);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      aAddr_q  <= 12'h000;
    end else if (clkEn) begin
      wrPend_q <= accept && hwrite;
      rdPend_q <= accept && !hwrite;
      aAddr_q  <= haddr[`SPHP_ADDR_W-1:0];
    end
  end

  // Control register; plot-go and plot-end are write-only pulses
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      ctrl_q <= `SPHP_CTRL_RESET;
    else if (clkEn && wrPend_q && aAddr_q == `SPHP_CTRL_ADDR)
      ctrl_q <= {25'h0000000, hwdata[`SPHP_CTRL_HOST:0]};
  end

  // ========================================================================
  // Plot session: host mode locks it out, init sequence sent first
  logic plotAct_q;
  logic hostMode;
  assign hostMode = ctrl_q[`SPHP_CTRL_HOST];
  assign plotMode = plotAct_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      plotAct_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (clkEn) begin
      if (plotGo && (hostMode || hwdata[`SPHP_CTRL_HOST]))
        refused_q <= 1'b1;
      else if (plotGo)
        refused_q <= 1'b0;
      if (plotGo && !hostMode && !hwdata[`SPHP_CTRL_HOST])
        plotAct_q <= 1'b1;
      else if (plotEnd)
        plotAct_q <= 1'b0;
    end
  end

  // Init characters: ESC . K ESC . R
  function automatic logic [7:0] initChar(input logic [2:0] i);
    case (i)
      3'h0, 3'h3: initChar = `SPHP_CH_ESC;
      3'h1, 3'h4: initChar = `SPHP_CH_DOT;
      3'h2:       initChar = `SPHP_CH_K;
      default:    initChar = `SPHP_CH_R;
    endcase
  endfunction

  // ========================================================================
  // Transmitter
  sphp_tx_t   txSt_q;
  logic [3:0] txPh_q;
  logic [2:0] txBit_q;
  logic [7:0] txSh_q;
  logic       initBusy;
  logic       loadChar;
  logic [7:0] nextChar;

  assign initBusy = plotAct_q && initIdx_q != `SPHP_INIT_DONE;
  assign nextChar = initBusy ? initChar(initIdx_q) : txHold_q;
  assign loadChar = txSt_q == SPHP_TX_IDLE && ctsLine_q && (initBusy || txFull_q) && tick;

  // Holding buffer; user data waits behind init characters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txHold_q  <= 8'h00;
      txFull_q  <= 1'b0;
      initIdx_q <= `SPHP_INIT_DONE;
    end else if (clkEn) begin
      if (plotGo && !hostMode && !hwdata[`SPHP_CTRL_HOST])
        initIdx_q <= 3'h0;
      else if (loadChar && initBusy)
        initIdx_q <= initIdx_q + 3'h1;
      if (txReq && !txFull_q) begin        // Write when full is dropped
        txHold_q <= hwdata[7:0];
        txFull_q <= 1'b1;
      end else if (loadChar && !initBusy)
        txFull_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txSt_q  <= SPHP_TX_IDLE;
      txPh_q  <= 4'h0;
      txBit_q <= 3'h0;
      txSh_q  <= 8'h00;
      txd     <= 1'b1;
    end else if (clkEn) begin
      if (tick && txSt_q != SPHP_TX_IDLE)
        txPh_q <= txPh_q + 4'h1;
      case (txSt_q)
        SPHP_TX_IDLE: begin
          txd <= 1'b1;
          if (loadChar) begin
            txSh_q <= nextChar;
            txSt_q <= SPHP_TX_START;
            txPh_q <= 4'h0;
            txd    <= 1'b0;
          end
        end
        SPHP_TX_START: if (tick && txPh_q == `SPHP_PH_LAST) begin
          txSt_q  <= SPHP_TX_DATA;
          txBit_q <= 3'h0;
          txd     <= txSh_q[0];
        end
        SPHP_TX_DATA: if (tick && txPh_q == `SPHP_PH_LAST) begin
          txBit_q <= txBit_q + 3'h1;
          if (txBit_q == 3'h7) begin
            txSt_q <= (parMode == SPHP_PAR_NONE) ? SPHP_TX_STOP1 : SPHP_TX_PAR;
            txd    <= (parMode == SPHP_PAR_NONE) ? 1'b1 : sphp_parity(txSh_q, parMode);
          end else
            txd <= txSh_q[txBit_q + 3'h1];
        end
        SPHP_TX_PAR: if (tick && txPh_q == `SPHP_PH_LAST) begin
          txSt_q <= SPHP_TX_STOP1;
          txd    <= 1'b1;
        end
        SPHP_TX_STOP1: if (tick && txPh_q == `SPHP_PH_LAST) begin
          txSt_q <= (plotMode || ctrl_q[`SPHP_CTRL_STOP2]) ? SPHP_TX_STOP2
                                                           : SPHP_TX_IDLE;
        end
        SPHP_TX_STOP2: if (tick && txPh_q == `SPHP_PH_LAST)
          txSt_q <= SPHP_TX_IDLE;
        default: txSt_q <= SPHP_TX_IDLE;
      endcase
    end
  end

  // Space requests transmission while a character waits or is on the line
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      rtsN <= 1'b1;
    else if (clkEn)
      rtsN <= !(initBusy || txFull_q || txSt_q != SPHP_TX_IDLE);
  end

  // ========================================================================
  // Receiver and read side
  logic       rxStrobe;
  logic [7:0] rxByte;
  logic       rxPe;
  logic       rxFe;

  sphp_rx u_rx (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .tick     (tick),
    .rxLine   (rxLine_q),
    .parMode  (parMode),
    .rxStrobe (rxStrobe),
    .rxByte   (rxByte),
    .rxParErr (rxPe),
    .rxFrmErr (rxFe)
  );

  // Valid flag: a new character wins over the clearing read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxData_q  <= 8'h00;
      rxValid_q <= 1'b0;
      parErr_q  <= 1'b0;
      frmErr_q  <= 1'b0;
    end else if (clkEn) begin
      if (rxStrobe) begin
        rxData_q  <= rxByte;
        rxValid_q <= 1'b1;
        parErr_q  <= rxPe;
        frmErr_q  <= rxFe;
      end else if (rdPend_q && aAddr_q == `SPHP_RXDATA_ADDR)
        rxValid_q <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rdPend_q) begin
      case (aAddr_q)
        `SPHP_CTRL_ADDR:   hrdata = ctrl_q;
        `SPHP_STATUS_ADDR: begin
          hrdata[`SPHP_ST_TXRDY]   = !txFull_q;
          hrdata[`SPHP_ST_RXVALID] = rxValid_q;
          hrdata[`SPHP_ST_PARERR]  = parErr_q;
          hrdata[`SPHP_ST_FRMERR]  = frmErr_q;
          hrdata[`SPHP_ST_PLOT]    = plotAct_q;
          hrdata[`SPHP_ST_BUSY]    = txSt_q != SPHP_TX_IDLE;
          hrdata[`SPHP_ST_CTS]     = ctsLine_q;
          hrdata[`SPHP_ST_REFUSED] = refused_q;
        end
        `SPHP_RXDATA_ADDR: hrdata[7:0] = rxData_q;
        default:           hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Checks
  sequence charStart;
    $past(txSt_q) == SPHP_TX_IDLE && txSt_q == SPHP_TX_START;
  endsequence

  idle_mark_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(txSt_q) == SPHP_TX_IDLE && txSt_q == SPHP_TX_IDLE |-> txd)
    else $error("transmit line not at mark while idle");
  cts_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    charStart |-> $past(ctsLine_q)) else $error("character started without clear to send");
  start_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    charStart |-> !txd) else $error("start bit not space");
  plot_par_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    plotAct_q |-> txSt_q != SPHP_TX_PAR) else $error("parity bit in plot mode");
  plot_stop2_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    plotAct_q && txSt_q == SPHP_TX_STOP1 && clkEn && tick && txPh_q == `SPHP_PH_LAST
    |=> txSt_q == SPHP_TX_STOP2) else $error("plot frame lacks second stop");
  host_excl_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    hostMode && !$past(plotAct_q) |-> !plotAct_q) else $error("plot runs during host mode");
  init_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    loadChar && plotAct_q && initIdx_q == 3'h0 |-> nextChar == `SPHP_CH_ESC)
    else $error("plot not opened by escape");
  rts_req_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && txSt_q != SPHP_TX_IDLE |=> !rtsN) else $error("request not space during frame");
  stop_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !plotAct_q && !ctrl_q[`SPHP_CTRL_STOP2] |-> txSt_q != SPHP_TX_STOP2)
    else $error("second stop sent when one selected");
endmodule
`default_nettype wire

// *** rtl/sphp_regs.svh ***
// ==========================================================================
// How it works
// - Plot mode forces frame: start, eight data, two stop, no parity.
// - Plot mode sends the init sequence, then only the supplied stream; no delimiter is appended.
// - Plot start refused while host communication is active; host mode is not refused during a plot.
// - Plot begins by sending ESC . K then ESC . R before any data.
// - Baud selectable among 300, 600, 1200, 2400, 4800, 9600; far end matches.
// - Transmit line idles at mark (one) between characters.
// - Request-to-send low requests transmission, high requests stop.
// - Independent serial transmit output and receive input.
// - Stop bits per character configurable as one or two.
// - Parity none, odd or even; parity bit follows the data bits.
`ifndef SPHP_REGS_SVH
`define SPHP_REGS_SVH

// ==========================================================================
// Register map (byte addresses)
`define SPHP_CTRL_ADDR    12'h000
`define SPHP_STATUS_ADDR  12'h004
`define SPHP_TXDATA_ADDR  12'h008
`define SPHP_RXDATA_ADDR  12'h00c
`define SPHP_ADDR_W       12

// ==========================================================================
// Control fields
`define SPHP_CTRL_BAUD_LSB   0
`define SPHP_CTRL_BAUD_MSB   2
`define SPHP_CTRL_STOP2      3
`define SPHP_CTRL_PAR_LSB    4
`define SPHP_CTRL_PAR_MSB    5
`define SPHP_CTRL_HOST       6
`define SPHP_CTRL_PLOTGO     7
`define SPHP_CTRL_PLOTEND    8
`define SPHP_CTRL_RESET      32'h0000_0005

// ==========================================================================
// Status fields
`define SPHP_ST_TXRDY    0
`define SPHP_ST_RXVALID  1
`define SPHP_ST_PARERR   2
`define SPHP_ST_FRMERR   3
`define SPHP_ST_PLOT     4
`define SPHP_ST_BUSY     5
`define SPHP_ST_CTS      6
`define SPHP_ST_REFUSED  7

// ==========================================================================
// Bit timing: one tick is sixteen per bit
`define SPHP_CLK_HZ      200000000
`define SPHP_OVERSAMPLE  16
`define SPHP_BAUD_300    300
`define SPHP_BAUD_600    600
`define SPHP_BAUD_1200   1200
`define SPHP_BAUD_2400   2400
`define SPHP_BAUD_4800   4800
`define SPHP_BAUD_9600   9600
`define SPHP_PH_LAST     4'hf
`define SPHP_PH_MID      4'h7
`define SPHP_RX_END_NP   4'h9
`define SPHP_RX_END_P    4'ha
`define SPHP_INIT_DONE   3'h6

// ==========================================================================
// Plotter init characters
`define SPHP_CH_ESC   8'h1b
`define SPHP_CH_DOT   8'h2e
`define SPHP_CH_K     8'h4b
`define SPHP_CH_R     8'h52

`endif

// *** rtl/sphp_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sphp_regs.svh"
module sphp_rx
  import sphp_pkg::*;
(
  input  wire logic       sys_clk,    // System clock
  input  wire logic       rstn,       // Async reset, low
  input  wire logic       clkEn,      // Freeze when low
  input  wire logic       tick,       // Sixteen per bit
  input  wire logic       rxLine,     // Synchronised receive line
  input  wire sphp_par_t  parMode,    // Parity selection
  output logic            rxStrobe,   // One-cycle char done
  output logic [7:0]      rxByte,     // Received character
  output logic            rxParErr,   // Parity mismatch
  output logic            rxFrmErr    // Stop bit low
);
  logic [3:0] phase_q;
  logic [3:0] bitIdx_q;
  logic       active_q;
  logic [8:0] shift_q;
  logic [3:0] lastBit;

  // Data, optional parity, then one stop bit
  assign lastBit = (parMode == SPHP_PAR_NONE) ? `SPHP_RX_END_NP : `SPHP_RX_END_P;

  // ========================================================================
  // Frame sampler: mid-bit samples, start re-checked to reject glitches
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      active_q <= 1'b0;
      phase_q  <= 4'h0;
      bitIdx_q <= 4'h0;
      shift_q  <= 9'h000;
      rxStrobe <= 1'b0;
      rxByte   <= 8'h00;
      rxParErr <= 1'b0;
      rxFrmErr <= 1'b0;
    end else if (clkEn) begin
      rxStrobe <= 1'b0;
      if (!active_q) begin
        if (!rxLine && tick) begin
          active_q <= 1'b1;
          phase_q  <= 4'h1;
          bitIdx_q <= 4'h0;
        end
      end else if (tick) begin
        phase_q <= phase_q + 4'h1;
        if (phase_q == `SPHP_PH_MID) begin
          if (bitIdx_q == 4'h0 && rxLine) begin
            active_q <= 1'b0;          // False start
          end else if (bitIdx_q == lastBit) begin
            active_q <= 1'b0;
            rxStrobe <= 1'b1;
            rxByte   <= shift_q[7:0];
            rxFrmErr <= ~rxLine;
            rxParErr <= (parMode != SPHP_PAR_NONE) &&
                        (shift_q[8] != sphp_parity(shift_q[7:0], parMode));
          end else begin
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q != 4'h0) begin
              if (bitIdx_q <= 4'h8)
                shift_q <= {1'b0, rxLine, shift_q[7:1]};
              else
                shift_q[8] <= rxLine;
            end
          end
        end
      end
    end
  end

  rx_frame_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rxStrobe |-> !$past(rxStrobe)) else $error("receive strobe longer than one cycle");
endmodule
`default_nettype wire

// *** tb/serial_plot_host_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sphp_regs.svh"
// ==========================================================
// Compare macro; arguments must be free of side effects
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); num_errors++; end end
module serial_plot_host_port_tb;
  logic        sys_clk;
  logic        rstn;
  logic        hwrite;
  logic        hsel;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic        hreadyout;
  logic        hresp;
  logic        txd;
  logic        rxd;
  logic        rtsN;
  logic        cts;
  logic [11:0] fr;
  int          num_errors;
  int          total_checks;
  // Rate handed to the divider; keeps a bit at 160 cycles at 9600 so the run stays short
  localparam int unsigned BENCH_HZ = 1536000;

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Single slave, so its ready is the bus ready
  sphp_port #(.CLK_HZ(BENCH_HZ)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .rxd(rxd),
    .rtsN(rtsN), .cts(cts)
  );
  sphp_far_model u_far (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .cts(cts));

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic fail();
    num_errors++;
    report_and_stop();
  endtask

  task automatic doReset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  // Address phase, then data phase; each ends at an edge with ready high
  task automatic busXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    // Ready is judged and read data taken at the rising edge that ends each phase
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
        if (n > 50) fail();
      end while (hreadyout !== 1'b1);
      rd = hrdata;
      if (ph == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
  endtask

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
    busXfer(a, 1'b1, d);
  endtask

  task automatic rdReg(input logic [11:0] a);
    busXfer(a, 1'b0, 32'h0);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic waitFall();
    int n;
    n = 0;
    while (txd !== 1'b0) begin
      @(negedge sys_clk);
      n++;
      if (n > 2000) fail();
    end
  endtask

  task automatic waitFrames(input int k);
    int n;
    n = 0;
    while (u_far.rxq.size() < k) begin
      @(negedge sys_clk);
      n++;
      if (n > 20000) fail();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic testReset();
    @(negedge sys_clk);
    `CHK(txd, 1'b1)
    `CHK(rtsN, 1'b1)
    `CHK({hreadyout, hresp}, 2'b10)
    rdReg(`SPHP_CTRL_ADDR);
    `CHK(rd, 32'h0000_0005)
  endtask

  // Two stops shown by a second frame sent straight after the first
  task automatic testHostTx();
    u_far.slots = 12;
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_006d);
    wrReg(`SPHP_TXDATA_ADDR, 32'h0000_0007);
    waitCyc(40);
    wrReg(`SPHP_TXDATA_ADDR, 32'h0000_0080);
    waitFrames(2);
    fr = u_far.rxq.pop_front();
    `CHK(fr, 12'he0e)
    fr = u_far.rxq.pop_front();
    `CHK(fr, 12'hf00)
    // Let the second stop bit end before the stop count is changed
    waitCyc(120);
    u_far.slots = 11;
  endtask

  // Stalled start, then clear dropped mid-frame; the frame still completes
  task automatic testCts();
    u_far.ready <= 1'b0;
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_0005);
    wrReg(`SPHP_TXDATA_ADDR, 32'h0000_005a);
    waitCyc(2000);
    `CHK(u_far.rxq.size(), 0)
    `CHK(txd, 1'b1)
    `CHK(rtsN, 1'b0)
    rdReg(`SPHP_STATUS_ADDR);
    `CHK({rd[6:5], rd[0]}, 3'b000)
    u_far.ready <= 1'b1;
    waitFall();
    u_far.ready <= 1'b0;
    waitFrames(1);
    fr = u_far.rxq.pop_front();
    `CHK(fr, 12'heb4)
    waitCyc(200);
    `CHK(rtsN, 1'b1)
    u_far.ready <= 1'b1;
  endtask

  // Odd parity receive, good then bad parity bit
  task automatic testRx();
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_0015);
    u_far.sendChar(8'h96, 1'b1);
    waitCyc(20);
    rdReg(`SPHP_STATUS_ADDR);
    `CHK(rd[2:1], 2'b01)
    rdReg(`SPHP_RXDATA_ADDR);
    `CHK(rd[7:0], 8'h96)
    rdReg(`SPHP_STATUS_ADDR);
    `CHK(rd[1], 1'b0)
    u_far.sendChar(8'h96, 1'b0);
    waitCyc(20);
    rdReg(`SPHP_STATUS_ADDR);
    `CHK(rd[2:1], 2'b11)
  endtask

  // Even parity in CTRL must be overridden; a parity slot would read low for every character but R
  task automatic testPlot();
    logic [7:0] seq [7];
    seq = '{8'h1b, 8'h2e, 8'h4b, 8'h1b, 8'h2e, 8'h52, 8'h41};
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_0045);
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_00c5);
    rdReg(`SPHP_STATUS_ADDR);
    `CHK(rd[7], 1'b1)
    `CHK(rd[4], 1'b0)
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_0025);
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_00a5);
    wrReg(`SPHP_TXDATA_ADDR, 32'h0000_0041);
    waitFrames(7);
    for (int i = 0; i < 7; i++) begin
      fr = u_far.rxq.pop_front();
      `CHK(fr, {3'h7, seq[i], 1'b0})
    end
    // A delimiter frame would only be captured a full frame after it starts
    waitCyc(1900);
    `CHK(u_far.rxq.size(), 0)
    wrReg(`SPHP_CTRL_ADDR, 32'h0000_0105);
  endtask

  // Start-bit length at every rate; reset cuts each frame short
  task automatic testBaud();
    int rates [6];
    int n;
    int e;
    rates = '{300, 600, 1200, 2400, 4800, 9600};
    for (int b = 0; b < 6; b++) begin
      wrReg(`SPHP_CTRL_ADDR, b);
      wrReg(`SPHP_TXDATA_ADDR, 32'h0000_00ff);
      waitFall();
      n = 0;
      while (txd === 1'b0) begin
        @(negedge sys_clk);
        n++;
        if (n > 6000) fail();
      end
      e = (BENCH_HZ / (rates[b] * 16)) * 16;
      `CHK(n >= e - 32 && n <= e + 32, 1'b1)
      doReset();
      @(negedge sys_clk);
      `CHK(txd, 1'b1)
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsel = 1'b0;
    num_errors = 0;
    total_checks = 0;
    doReset();
    testReset();
    testHostTx();
    testCts();
    testRx();
    testPlot();
    testBaud();
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** tb/sphp_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far end of the link: host computer or pen plotter
module sphp_far_model (
  input  wire logic sys_clk,  // System clock
  input  wire logic txd,      // Port transmit line
  output logic      rxd,      // Port receive line
  output logic      cts       // Clear to send, mark ready
);
  int          bitCyc = 160;    // Cycles per bit at 9600 on the bench rate
  int          slots = 11;      // Bit slots captured per frame
  logic        ready = 1'b1;    // Bench sets this to stall the port
  logic [11:0] frame;
  logic [11:0] rxq[$];          // Captured frames, slot 0 is the start bit

  // Mark means ready to take data
  assign cts = ready;

  // Receive line rests at mark until a character is sent
  initial rxd = 1'b1;

  // Sample mid-bit from each falling edge; slots past the count read as mark
  always begin
    @(negedge txd);
    frame = '1;
    repeat (bitCyc / 2) @(posedge sys_clk);
    for (int i = 0; i < slots; i++) begin
      frame[i] = txd;
      if (i < slots - 1) repeat (bitCyc) @(posedge sys_clk);
    end
    rxq.push_back(frame);
  end

  // Send start, eight data LSB first, one parity bit, one stop
  task automatic sendChar(input logic [7:0] d, input logic p);
    logic [9:0] b;
    b = {p, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      rxd <= b[i];
      repeat (bitCyc - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rxd <= 1'b1;
    repeat (bitCyc - 1) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire
